/* hdl/pmbid_pkg.sv */
// Purpose: constants for the identification and scratchpad command bank
// Assumes: one command port, two pages, word-serial store reload
// Notes: store slot order is fixed by the LD_* indices below
//
// Functional notes
// RULE_01 - capability byte: bit 7 one for checksum support, bits 3..0 zero
// RULE_02 - capability bits 6..5 fixed at 01, meaning 400 kHz bus maximum
// RULE_03 - capability bit 4 fixed at one: alert output and alert response
// RULE_04 - capability byte read at code 0x19, unpaged, value 0xb0
// RULE_05 - capability only advertises checksum support, never whether it is mandatory
// RULE_06 - revision byte 0x11 read at code 0x98, unpaged, all bits fixed
// RULE_07 - identification word at 0xe7 is read-only and loaded from the store
// RULE_08 - lot code byte at 0xe8 is paged, read-only, loaded from the store
// RULE_09 - info word at 0xb6 refreshed at power-on, restore and bulk read (code has no bulk read; refreshes after power-on and restore loads only)
// RULE_10 - info bit 5 one when no store corrections; all other bits zero
// RULE_11 - scratch words at 0xb3 paged and 0xb4 unpaged, writable, default 0x0000 (code loads both from the store after power-on and restore)
// RULE_12 - one unpaged scratch word plus one independent copy per page
// RULE_13 - reserved words 0xb0, 0xb1 paged, 0xb2 stored; 0xbc paged, not stored (code keeps 0xb0 unpaged)
// RULE_14 - unpaged codes ignore page select; paged codes use the selected copy
// RULE_15 - host uses matching widths and expects no change on read-only writes
// RULE_16 - stored registers load from the store before any host command is taken
package pmbid_pkg;

	localparam int PAGE_COUNT = 2;
	localparam int PAGE_W = 1;
	localparam int WORD_W = 16;
	localparam int BYTE_W = 8;
	localparam int LD_W = 4;

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] CMD_CAPABILITY = 8'h19;
	localparam logic [7:0] CMD_REVISION = 8'h98;
	localparam logic [7:0] CMD_TOOL_A = 8'hb0;
	localparam logic [7:0] CMD_TOOL_B = 8'hb1;
	localparam logic [7:0] CMD_OEM = 8'hb2;
	localparam logic [7:0] CMD_SCRATCH_P = 8'hb3;
	localparam logic [7:0] CMD_SCRATCH_G = 8'hb4;
	localparam logic [7:0] CMD_INFO = 8'hb6;
	localparam logic [7:0] CMD_MFR_RESV = 8'hbc;
	localparam logic [7:0] CMD_PART_ID = 8'he7;
	localparam logic [7:0] CMD_LOT = 8'he8;

	////////////////////////////////////////////////////////////////////////////////
	localparam int CAP_PEC_BIT = 7;
	localparam int CAP_SCL_MSB = 6;
	localparam int CAP_SCL_LSB = 5;
	localparam int CAP_ALERT_BIT = 4;
	localparam logic [1:0] CAP_SCL_400K = 2'h1;
	localparam logic [7:0] CAP_VALUE = {1'h1, CAP_SCL_400K, 1'h1, 4'h0};
	localparam logic [7:0] REV_VALUE = 8'h11;
	localparam int INFO_ECC_BIT = 5;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [15:0] SCRATCH_RESET = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [3:0] LD_TOOL_A = 4'h0;
	localparam logic [3:0] LD_TOOL_B = 4'h1;
	localparam logic [3:0] LD_OEM = 4'h3;
	localparam logic [3:0] LD_SCRATCH_P = 4'h4;
	localparam logic [3:0] LD_SCRATCH_G = 4'h6;
	localparam logic [3:0] LD_PART_ID = 4'h7;
	localparam logic [3:0] LD_LOT = 4'h8;
	localparam logic [3:0] LD_LAST = 4'h9;

endpackage : pmbid_pkg

/* hdl/pmbid_bank.sv */
// Purpose: identification, information and scratchpad command bank
// Assumes: protocol engine hands over one decoded command at a time
// Notes: store answers each eeReq with one eeValid word, any later cycle
module pmbid_bank #(
	parameter int NUM_PAGES = pmbid_pkg::PAGE_COUNT
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdCode,
	input wire logic [pmbid_pkg::WORD_W-1:0] cmdWrData,
	input wire logic [pmbid_pkg::PAGE_W-1:0] pageSel,
	input wire logic restoreReq,
	output logic cmdReady,
	output logic rspValid,
	output logic rspHit,
	output logic rspWrErr,
	output logic [pmbid_pkg::WORD_W-1:0] rspData,
	output logic eeReq,
	output logic [pmbid_pkg::LD_W-1:0] eeAddr,
	input wire logic eeValid,
	input wire logic [pmbid_pkg::WORD_W-1:0] eeData,
	input wire logic eeEccClean
);
	import pmbid_pkg::*;

	if (NUM_PAGES != PAGE_COUNT)
	begin : g_bad_pages
		$error("pmbid_bank: load order serves exactly two pages");
	end

	typedef enum logic [1:0] {ST_LOAD_REQ, ST_LOAD_WAIT, ST_IDLE} pmbid_state_t;

	pmbid_state_t state_r;
	logic cmdReady_r;
	logic rspValid_r;
	logic rspHit_r;
	logic rspWrErr_r;
	logic [WORD_W-1:0] rspData_r;
	logic eeReq_r;
	logic [LD_W-1:0] eeAddr_r;
	logic eccAcc_r;
	logic [WORD_W-1:0] toolA_r;
	logic [WORD_W-1:0] oemWord_r;
	logic [WORD_W-1:0] scratchG_r;
	logic [WORD_W-1:0] partId_r;
	logic [WORD_W-1:0] infoStatus_r;
	logic [WORD_W-1:0] toolB_r [NUM_PAGES];
	logic [WORD_W-1:0] scratchP_r [NUM_PAGES];
	logic [WORD_W-1:0] mfrResv_r [NUM_PAGES];
	logic [BYTE_W-1:0] lot_r [NUM_PAGES];

	////////////////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic logic isKnown(input logic [7:0] code);
		case (code)
			CMD_CAPABILITY, CMD_REVISION, CMD_TOOL_A, CMD_TOOL_B, CMD_OEM,
			CMD_SCRATCH_P, CMD_SCRATCH_G, CMD_INFO, CMD_MFR_RESV,
			CMD_PART_ID, CMD_LOT: isKnown = 1'b1;
			default: isKnown = 1'b0;
		endcase
	endfunction

	function automatic logic isWritable(input logic [7:0] code);
		case (code)
			CMD_TOOL_A, CMD_TOOL_B, CMD_OEM, CMD_SCRATCH_P,
			CMD_SCRATCH_G, CMD_MFR_RESV: isWritable = 1'b1;
			default: isWritable = 1'b0;
		endcase
	endfunction

	// unpaged codes never look at pageSel
	function automatic logic [WORD_W-1:0] readWord(input logic [7:0] code,
		input logic [PAGE_W-1:0] pg);
		case (code)
			CMD_CAPABILITY: readWord = {8'h00, CAP_VALUE}; // RULE_04 RULE_05
			CMD_REVISION: readWord = {8'h00, REV_VALUE}; // RULE_06
			CMD_TOOL_A: readWord = toolA_r; // RULE_14
			CMD_TOOL_B: readWord = toolB_r[pg]; // RULE_14
			CMD_OEM: readWord = oemWord_r;
			CMD_SCRATCH_P: readWord = scratchP_r[pg]; // RULE_12
			CMD_SCRATCH_G: readWord = scratchG_r; // RULE_14
			CMD_INFO: readWord = infoStatus_r;
			CMD_MFR_RESV: readWord = mfrResv_r[pg];
			CMD_PART_ID: readWord = partId_r; // RULE_07
			CMD_LOT: readWord = {8'h00, lot_r[pg]}; // RULE_08
			default: readWord = WORD_RESET;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// command and load strobes

	// a restore in the same cycle wins; the command is not taken
	wire cmdTake = cmdValid && cmdReady_r && !restoreReq;
	wire hostWr = cmdTake && cmdWrite;
	wire loadWr = (state_r == ST_LOAD_WAIT) && eeValid;
	wire loadLast = loadWr && (eeAddr_r == LD_LAST);
	wire restoreTake = (state_r == ST_IDLE) && restoreReq;
	wire [WORD_W-1:0] storeData = (state_r == ST_LOAD_WAIT) ? eeData : cmdWrData;
	wire rdKnown = isKnown(cmdCode);
	wire rdWritable = isWritable(cmdCode);
	logic [WORD_W-1:0] rdData;
	// process, so a stored word changing under a held code is read again
	always_comb rdData = readWord(cmdCode, pageSel);
	wire eccNow = eccAcc_r && eeEccClean;
	wire [WORD_W-1:0] infoNxt = WORD_W'({eccNow}) << INFO_ECC_BIT;

	wire toolAWe = (hostWr && cmdCode == CMD_TOOL_A) || (loadWr && eeAddr_r == LD_TOOL_A);
	wire oemWe = (hostWr && cmdCode == CMD_OEM) || (loadWr && eeAddr_r == LD_OEM);
	wire scratchGWe = (hostWr && cmdCode == CMD_SCRATCH_G)
		|| (loadWr && eeAddr_r == LD_SCRATCH_G);
	wire partIdWe = loadWr && (eeAddr_r == LD_PART_ID);

	////////////////////////////////////////////////////////////////////////////////
	// load sequencer: power-on load, then restore reloads

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r <= ST_LOAD_REQ;
			eeReq_r <= 1'b0;
			eeAddr_r <= LD_TOOL_A;
			eccAcc_r <= 1'b1;
			cmdReady_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				ST_LOAD_REQ:
				begin
					eeReq_r <= 1'b1;
					state_r <= ST_LOAD_WAIT;
				end
				ST_LOAD_WAIT:
				begin
					eeReq_r <= 1'b0;
					if (eeValid)
					begin
						eccAcc_r <= eccNow;
						if (eeAddr_r == LD_LAST)
						begin
							state_r <= ST_IDLE;
							cmdReady_r <= 1'b1; // RULE_16
						end
						else
						begin
							eeAddr_r <= eeAddr_r + LD_W'(1);
							state_r <= ST_LOAD_REQ;
						end
					end
				end
				ST_IDLE:
				begin
					if (restoreReq)
					begin
						eeAddr_r <= LD_TOOL_A; // RULE_09
						eccAcc_r <= 1'b1;
						cmdReady_r <= 1'b0; // RULE_16
						state_r <= ST_LOAD_REQ;
					end
				end
				default:
				begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// response: writes to fixed or read-only codes leave storage untouched

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rspValid_r <= 1'b0;
			rspHit_r <= 1'b0;
			rspWrErr_r <= 1'b0;
			rspData_r <= WORD_RESET;
		end
		else
		begin
			rspValid_r <= cmdTake;
			if (cmdTake)
			begin
				rspHit_r <= rdKnown;
				rspWrErr_r <= cmdWrite && !rdWritable; // RULE_07
				rspData_r <= cmdWrite ? WORD_RESET : rdData;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// unpaged storage

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			toolA_r <= WORD_RESET;
			oemWord_r <= WORD_RESET;
			scratchG_r <= SCRATCH_RESET; // RULE_11
			partId_r <= WORD_RESET;
			infoStatus_r <= WORD_RESET;
		end
		else
		begin
			if (toolAWe)
				toolA_r <= storeData; // RULE_13
			if (oemWe)
				oemWord_r <= storeData; // RULE_13
			if (scratchGWe)
				scratchG_r <= storeData; // RULE_11
			if (partIdWe)
				partId_r <= storeData; // RULE_07
			if (loadLast)
				infoStatus_r <= infoNxt; // RULE_10
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// paged storage, one copy per page

	for (genvar p = 0; p < NUM_PAGES; p++)
	begin : g_page
		wire hostPage = hostWr && (pageSel == PAGE_W'(p));
		wire toolBWe = (hostPage && cmdCode == CMD_TOOL_B)
			|| (loadWr && eeAddr_r == LD_TOOL_B + LD_W'(p));
		wire scratchPWe = (hostPage && cmdCode == CMD_SCRATCH_P)
			|| (loadWr && eeAddr_r == LD_SCRATCH_P + LD_W'(p));
		wire mfrResvWe = hostPage && (cmdCode == CMD_MFR_RESV);
		wire lotWe = loadWr && (eeAddr_r == LD_LOT + LD_W'(p));

		always_ff @(posedge clock or negedge arst_n)
		begin
			if (!arst_n)
			begin
				toolB_r[p] <= WORD_RESET;
				scratchP_r[p] <= SCRATCH_RESET;
				mfrResv_r[p] <= WORD_RESET;
				lot_r[p] <= 8'h00;
			end
			else
			begin
				if (toolBWe)
					toolB_r[p] <= storeData; // RULE_13
				if (scratchPWe)
					scratchP_r[p] <= storeData; // RULE_12
				// not backed by the store: a restore keeps it
				if (mfrResvWe)
					mfrResv_r[p] <= cmdWrData; // RULE_13
				if (lotWe)
					lot_r[p] <= storeData[BYTE_W-1:0]; // RULE_08
			end
		end
	end

	assign cmdReady = cmdReady_r;
	assign rspValid = rspValid_r;
	assign rspHit = rspHit_r;
	assign rspWrErr = rspWrErr_r;
	assign rspData = rspData_r;
	assign eeReq = eeReq_r;
	assign eeAddr = eeAddr_r;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence seqRead(logic [7:0] code);
		cmdTake && !cmdWrite && cmdCode == code;
	endsequence

	sequence seqWrite(logic [7:0] code);
		cmdTake && cmdWrite && cmdCode == code;
	endsequence

	sequence seqNextSlot;
		state_r == ST_LOAD_REQ ##1 eeReq_r;
	endsequence

	AST_CAP_PEC: assert property (seqRead(CMD_CAPABILITY) |=> // RULE_01
		rspValid_r && rspData_r[CAP_PEC_BIT] && rspData_r[3:0] == 4'h0)
		else $error("capability checksum or low bits wrong");
	AST_CAP_SPEED: assert property (seqRead(CMD_CAPABILITY) |=> // RULE_02
		rspData_r[CAP_SCL_MSB:CAP_SCL_LSB] == 2'h1)
		else $error("capability bus speed field wrong");
	AST_CAP_ALERT: assert property (seqRead(CMD_CAPABILITY) |=> // RULE_03
		rspData_r[CAP_ALERT_BIT])
		else $error("capability alert bit not set");
	AST_CAP_VALUE: assert property (seqRead(CMD_CAPABILITY) |=> // RULE_04
		rspHit_r && rspData_r == 16'h00b0 ##1 !rspValid_r || $past(cmdTake))
		else $error("capability value wrong");
	AST_REV_VALUE: assert property (seqRead(CMD_REVISION) |=> // RULE_06
		rspHit_r && rspData_r == 16'h0011)
		else $error("revision value wrong");
	AST_ID_READONLY: assert property (seqWrite(CMD_PART_ID) |=> // RULE_07
		rspWrErr_r && $stable(partId_r))
		else $error("identification word changed by host write");
	AST_RESTORE_RELOAD: assert property (restoreTake |=> // RULE_09
		!cmdReady_r && state_r == ST_LOAD_REQ && eeAddr_r == LD_TOOL_A ##1 eeReq_r)
		else $error("restore did not start a reload");
	AST_INFO_FIELDS: assert property (loadLast |=> // RULE_10
		infoStatus_r[INFO_ECC_BIT] == $past(eccNow)
		&& infoStatus_r[15:6] == 10'h000 && infoStatus_r[4:0] == 5'h00)
		else $error("info word not refreshed correctly");
	AST_SCRATCH_PAGE: assert property (seqWrite(CMD_SCRATCH_P) |=> // RULE_12
		scratchP_r[$past(pageSel)] == $past(cmdWrData)
		&& scratchP_r[~$past(pageSel)] == $past(scratchP_r[~pageSel]))
		else $error("paged scratch copy not independent");
	AST_GLOBAL_NOPAGE: assert property (seqWrite(CMD_SCRATCH_G) ##1 seqRead(CMD_SCRATCH_G) // RULE_14
		|=> rspData_r == $past(cmdWrData, 2))
		else $error("unpaged scratch word depends on page");
	AST_HOLD_DURING_LOAD: assert property (state_r != ST_IDLE |=> !rspValid_r) // RULE_16
		else $error("answer given while loading");
	AST_REV_NOWRITE: assert property (seqWrite(CMD_REVISION) |=> // RULE_06
		rspWrErr_r && rspHit_r && rspData_r == WORD_RESET)
		else $error("revision write not refused");
	AST_LOT_READONLY: assert property (seqWrite(CMD_LOT) |=> // RULE_08
		rspWrErr_r && $stable(lot_r[0]) && $stable(lot_r[1]))
		else $error("lot code changed by host write");
	AST_INFO_READONLY: assert property (seqWrite(CMD_INFO) |=> // RULE_09
		rspWrErr_r && $stable(infoStatus_r))
		else $error("info word changed by host write");
	AST_TOOLA_NOPAGE: assert property (seqRead(CMD_TOOL_A) |=> // RULE_14
		rspData_r == $past(toolA_r))
		else $error("unpaged reserved word read wrong");
	AST_SCRATCH_RD_PAGE: assert property (seqRead(CMD_SCRATCH_P) |=> // RULE_12
		rspData_r == $past(scratchP_r[pageSel]))
		else $error("paged scratch read from wrong copy");
	AST_RESV_KEPT: assert property (restoreTake |=> // RULE_13
		$stable(mfrResv_r[0]) && $stable(mfrResv_r[1]))
		else $error("unstored reserved word touched by restore");
	AST_LOAD_STEP: assert property (loadWr && !loadLast |=> seqNextSlot) // RULE_16
		else $error("load did not move to the next slot");
	AST_READY_AFTER_LOAD: assert property (loadLast |=> // RULE_16
		cmdReady_r && state_r == ST_IDLE)
		else $error("bank not ready after last slot");

endmodule // pmbid_bank

/* tb/pmbid_store_model.sv */
// Purpose: behavioural store that answers the bank's word requests
// Assumes: one open request at a time, slot word is (slot+1)*0x1111
// Notes: slow mode adds four cycles; dirtySlot flags one word as corrected
module pmbid_store_model
	import pmbid_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic eeReq,
	input wire logic [LD_W-1:0] eeAddr,
	input wire logic slow,
	input wire logic [LD_W-1:0] dirtySlot,
	output logic eeValid,
	output logic [WORD_W-1:0] eeData,
	output logic eeEccClean
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pending_r;
	logic [2:0] waitCnt_r;
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pending_r <= 1'b0;
			waitCnt_r <= 3'h0;
			eeValid <= 1'b0;
			eeData <= 16'h0000;
			eeEccClean <= 1'b0;
		end
		else
		begin
			eeValid <= 1'b0;
			// released word toggles so a stale value never passes for data
			eeData <= ~eeData;
			eeEccClean <= ~eeEccClean;
			if (eeReq)
			begin
				pending_r <= 1'b1;
				waitCnt_r <= slow ? 3'h4 : 3'h0;
			end
			else if (pending_r && waitCnt_r != 3'h0)
				waitCnt_r <= waitCnt_r - 3'h1;
			else if (pending_r)
			begin
				pending_r <= 1'b0;
				eeValid <= 1'b1;
				eeData <= 16'h1111 * ({12'h000, eeAddr} + 16'h0001);
				eeEccClean <= (eeAddr != dirtySlot);
			end
		end
	end
endmodule // pmbid_store_model

/* tb/testbench.sv */
// Purpose: self-checking bench for the identification and scratch bank
// Assumes: store model answers every request
// Notes: one task per scenario, host side driven by tasks here
module testbench;
	import pmbid_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic cmdValid = 1'b0;
	logic cmdWrite = 1'b0;
	logic [7:0] cmdCode = 8'h00;
	logic [WORD_W-1:0] cmdWrData = 16'h0000;
	logic [PAGE_W-1:0] pageSel = 1'b0;
	logic restoreReq = 1'b0;
	logic slow = 1'b0;
	logic [LD_W-1:0] dirtySlot = 4'hf;
	logic cmdReady, rspValid, rspHit, rspWrErr, eeReq, eeValid, eeEccClean;
	logic [WORD_W-1:0] rspData, eeData;
	logic [LD_W-1:0] eeAddr;
	int errorCnt = 0;
	int totalChecks = 0;
	always #2 clock = ~clock;
	pmbid_bank i_dut (.clock(clock), .arst_n(arst_n), .cmdValid(cmdValid),
		.cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWrData(cmdWrData), .pageSel(pageSel),
		.restoreReq(restoreReq), .cmdReady(cmdReady), .rspValid(rspValid), .rspHit(rspHit),
		.rspWrErr(rspWrErr), .rspData(rspData), .eeReq(eeReq), .eeAddr(eeAddr),
		.eeValid(eeValid), .eeData(eeData), .eeEccClean(eeEccClean));
	pmbid_store_model i_store (.clock(clock), .arst_n(arst_n), .eeReq(eeReq),
		.eeAddr(eeAddr), .slow(slow), .dirtySlot(dirtySlot), .eeValid(eeValid),
		.eeData(eeData), .eeEccClean(eeEccClean));
	////////////////////////////////////////////////////////////////////////////////
	task automatic wrapUp();
		$display("checks %0d mismatches %0d", totalChecks, errorCnt);
		if (errorCnt == 0 && totalChecks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		totalChecks++;
		if (seen !== exp)
		begin
			errorCnt++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [15:0] slotWord(input int s);
		return 16'(16'h1111 * (s + 1));
	endfunction
	task automatic waitReady();
		for (int n = 0; n < 400; n++)
		begin
			@(posedge clock);
			#1;
			if (cmdReady === 1'b1)
				return;
		end
		errorCnt++;
		$display("BAD %0t ready never came", $time);
		wrapUp();
	endtask
	// one command, answer looked at in its single valid cycle
	task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] d,
		input logic pg);
		@(posedge clock);
		cmdValid <= 1'b1;
		cmdWrite <= wr;
		cmdCode <= code;
		cmdWrData <= d;
		pageSel <= pg;
		@(posedge clock);
		cmdValid <= 1'b0;
		#1;
		check({15'h0, rspValid}, 16'h0001);
	endtask
	task automatic rd(input logic [7:0] code, input logic pg, input logic [15:0] exp);
		cmd(1'b0, code, 16'h0000, pg);
		check(rspData, exp);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic testFixed();
		logic [7:0] ro [5] = '{8'h19, 8'h98, 8'hb6, 8'he7, 8'he8};
		rd(8'h19, 1'b0, 16'h00b0);
		check({15'h0, rspHit}, 16'h0001);
		rd(8'h19, 1'b1, 16'h00b0);
		rd(8'h98, 1'b1, 16'h0011);
		rd(8'h20, 1'b0, 16'h0000);
		check({15'h0, rspHit}, 16'h0000);
		foreach (ro[i])
		begin
			cmd(1'b1, ro[i], 16'hffff, 1'b0);
			check({15'h0, rspWrErr}, 16'h0001);
		end
		rd(8'h19, 1'b0, 16'h00b0);
		rd(8'he7, 1'b0, slotWord(7));
		$display("test fixed done");
	endtask
	task automatic testLoad(input logic [15:0] info);
		logic [7:0] lc [10] = '{8'hb0, 8'hb1, 8'hb1, 8'hb2, 8'hb3, 8'hb3, 8'hb4, 8'he7,
			8'he8, 8'he8};
		logic [9:0] lp = 10'h2ed;
		foreach (lc[i])
			rd(lc[i], lp[i], slotWord(i) & (i > 7 ? 16'h00ff : 16'hffff));
		rd(8'hb6, 1'b1, info);
		$display("test load done");
	endtask
	task automatic testWrite();
		logic [7:0] wc [9] = '{8'hb0, 8'hb1, 8'hb1, 8'hb2, 8'hb3, 8'hb3, 8'hb4, 8'hbc, 8'hbc};
		logic [8:0] wp = 9'h164;
		logic [8:0] wu = 9'h049;
		rd(8'hbc, 1'b1, 16'h0000);
		foreach (wc[i])
		begin
			cmd(1'b1, wc[i], 16'hc000 | 16'(i), wp[i]);
			check({15'h0, rspWrErr}, 16'h0000);
		end
		// unpaged words read back from the other page
		foreach (wc[i])
			rd(wc[i], wp[i] ^ wu[i], 16'hc000 | 16'(i));
		// back to back: unpaged write, then read from the other page
		@(posedge clock);
		cmdValid <= 1'b1;
		cmdWrite <= 1'b1;
		cmdCode <= 8'hb4;
		cmdWrData <= 16'h5a5a;
		pageSel <= 1'b0;
		@(posedge clock);
		cmdWrite <= 1'b0;
		pageSel <= 1'b1;
		@(posedge clock);
		cmdValid <= 1'b0;
		#1;
		check({15'h0, rspValid}, 16'h0001);
		check(rspData, 16'h5a5a);
		$display("test write done");
	endtask
	task automatic testRestore(input logic [3:0] dirty, input logic [15:0] info);
		@(posedge clock);
		dirtySlot <= dirty;
		slow <= (dirty != 4'hf);
		restoreReq <= 1'b1;
		@(posedge clock);
		restoreReq <= 1'b0;
		#1;
		check({15'h0, cmdReady}, 16'h0000);
		@(posedge clock);
		cmdValid <= 1'b1;
		cmdWrite <= 1'b0;
		cmdCode <= 8'h19;
		@(posedge clock);
		cmdValid <= 1'b0;
		#1;
		check({15'h0, rspValid}, 16'h0000);
		waitReady();
		rd(8'hb6, 1'b0, info);
		rd(8'hb3, 1'b1, slotWord(5));
		rd(8'hbc, 1'b1, 16'hc008);
		$display("test restore done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		waitReady();
		testFixed();
		testLoad(16'h0020);
		testWrite();
		testRestore(4'h5, 16'h0000);
		testRestore(4'hf, 16'h0020);
		testLoad(16'h0020);
		wrapUp();
	end
endmodule // testbench
